/* src/alu_flags_pkg.sv */
// constants, op codes and field layout shared by the flag register logic
package alu_flags_pkg;

   // register port geometry
   localparam int REG_ADDR_W = 4;
   localparam int REG_DATA_W = 8;
   localparam logic [REG_ADDR_W-1:0] ALU_FLAGS_OFS = 4'h0;

   // bit positions inside alu_flags
   localparam int CARRY_BIT = 0;
   localparam int NIBBLE_CARRY_BIT = 1;
   localparam int ZERO_BIT = 2;
   localparam int SIGNED_OVERFLOW_BIT = 3;
   localparam int NEGATIVE_BIT = 4;
   localparam int FLAG_W = 5;

   // values after reset
   localparam logic [FLAG_W-1:0] ALU_FLAGS_RST = 5'h00;
   localparam logic [7:0] RESULT_RST = 8'h00;
   localparam logic [2:0] UNIMPL_BITS = 3'h0;

   // flag groups touched by each class of instruction
   localparam logic [FLAG_W-1:0] MASK_ALL = 5'h1F;
   localparam logic [FLAG_W-1:0] MASK_LOGIC = 5'h14;
   localparam logic [FLAG_W-1:0] MASK_ZERO = 5'h04;
   localparam logic [FLAG_W-1:0] MASK_NONE = 5'h00;

   // instructions presented by the execution unit
   typedef enum logic [3:0] {
      OP_ADD = 4'h0,            // f + w
      OP_ADDC = 4'h1,           // f + w + carry
      OP_SUB = 4'h2,            // f - w, carry is not-borrow
      OP_SUBB = 4'h3,           // f - w - !carry
      OP_AND = 4'h4,
      OP_OR = 4'h5,
      OP_XOR = 4'h6,
      OP_INC = 4'h7,
      OP_DEC = 4'h8,
      OP_NEG = 4'h9,            // 0 - f
      OP_CLEAR_FILE = 4'hA,     // clear_file_instruction
      OP_NIBBLE_SWAP = 4'hB,    // nibble_swap_instruction
      OP_BIT_CLEAR = 4'hC,      // bit_clear_instruction
      OP_BIT_SET = 4'hD,        // bit_set_instruction
      OP_FILE_TO_FILE = 4'hE,   // file_to_file_move
      OP_WORKING_TO_FILE = 4'hF // working_to_file_move
   } alu_op_t;

endpackage : alu_flags_pkg

/* src/alu_status_flag_register.sv */
// alu status flag register with flag generation and a plain register port
//
// Notes on behaviour
// - flag register usable as any instruction operand
// - flag-affecting op to flags drops its result
// - clear-file on flags sets zero only
// - bit, swap and move ops keep flags unless the flags are their destination, then the result is written to them
// - subtraction carry and nibble carry mean not-borrow
// - bits 4..0 hold flags, 7..5 read zero
// - negative flag follows result bit seven
// - overflow flag marks signed sign change
// - zero flag marks all-zero result
`timescale 1ns/10ps

module alu_status_flag_register
   import alu_flags_pkg::*;
(
   input wire logic i_core_clk,                       // core clock, 50 MHz
   input wire logic i_nrst,                           // async reset, active low
   input wire logic i_exec_valid,                     // instruction executes this cycle
   input wire alu_op_t i_exec_op,                     // instruction kind
   input wire logic [7:0] i_operand_w,                // working register value
   input wire logic [7:0] i_operand_f,                // file operand value
   input wire logic i_src_is_flags,                   // file operand is the flag register
   input wire logic i_dest_is_flags,                  // destination is the flag register
   input wire logic [2:0] i_bit_sel,                  // bit number for bit set or clear
   input wire logic [REG_ADDR_W-1:0] i_reg_addr,      // register port address
   input wire logic [REG_DATA_W-1:0] i_reg_wdata,     // register port write data
   input wire logic i_reg_wr,                         // register port write strobe
   input wire logic i_reg_rd,                         // register port read strobe
   output logic [REG_DATA_W-1:0] o_reg_rdata,         // read data, cycle after strobe
   output logic [7:0] o_result,                       // registered instruction result
   output logic o_result_we,                          // result goes to its file target
   output logic [FLAG_W-1:0] o_flags                  // current flag values
);

   typedef struct packed {
      logic [FLAG_W-1:0] flags;
      logic [7:0] result;
      logic result_we;
      logic [REG_DATA_W-1:0] rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   // which flags an instruction is allowed to change
   function automatic logic [FLAG_W-1:0] flag_mask(input alu_op_t op);
      logic [FLAG_W-1:0] m;
      m = MASK_NONE;
      case (op)
         OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_INC, OP_DEC, OP_NEG: m = MASK_ALL;
         OP_AND, OP_OR, OP_XOR: m = MASK_LOGIC;
         OP_CLEAR_FILE: m = MASK_ZERO;
         default: m = MASK_NONE; // swap, bit and move ops leave flags alone
      endcase
      return m;
   endfunction : flag_mask

   // eight bit adder returning {carry, nibble carry, overflow, sum}
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
      logic [8:0] full;
      logic [4:0] low;
      logic ov;
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      ov = (a[7] == b[7]) && (full[7] != a[7]);
      return {full[8], low[4], ov, full[7:0]};
   endfunction : add8

   // flag register as presented on any read, upper bits fixed at zero
   logic [7:0] flags_byte;
   assign flags_byte = {UNIMPL_BITS, s_q.flags};

   // file operand is replaced by the flag register when it is the source
   logic [7:0] opnd_f;
   assign opnd_f = i_src_is_flags ? flags_byte : i_operand_f;

   logic carry_q;
   assign carry_q = s_q.flags[CARRY_BIT];

   // result and raw flags of the current instruction
   logic [7:0] res;
   logic [10:0] sum;
   logic arith;
   logic [FLAG_W-1:0] new_flags;
   logic [FLAG_W-1:0] mask;

   always_comb begin
      sum = 11'h000;
      res = RESULT_RST;
      arith = 1'b0;
      case (i_exec_op)
         OP_ADD: begin
            sum = add8(opnd_f, i_operand_w, 1'b0);
            arith = 1'b1;
         end
         OP_ADDC: begin
            sum = add8(opnd_f, i_operand_w, carry_q);
            arith = 1'b1;
         end
         // subtraction adds the complement, so a set carry means no borrow
         OP_SUB: begin
            sum = add8(opnd_f, ~i_operand_w, 1'b1);
            arith = 1'b1;
         end
         OP_SUBB: begin
            sum = add8(opnd_f, ~i_operand_w, carry_q);
            arith = 1'b1;
         end
         OP_INC: begin
            sum = add8(opnd_f, 8'h00, 1'b1);
            arith = 1'b1;
         end
         OP_DEC: begin
            sum = add8(opnd_f, 8'hFF, 1'b0);
            arith = 1'b1;
         end
         OP_NEG: begin
            sum = add8(8'h00, ~opnd_f, 1'b1);
            arith = 1'b1;
         end
         OP_AND: res = opnd_f & i_operand_w;
         OP_OR: res = opnd_f | i_operand_w;
         OP_XOR: res = opnd_f ^ i_operand_w;
         OP_CLEAR_FILE: res = 8'h00;
         OP_NIBBLE_SWAP: res = {opnd_f[3:0], opnd_f[7:4]};
         OP_BIT_CLEAR: res = opnd_f & ~(8'h01 << i_bit_sel);
         OP_BIT_SET: res = opnd_f | (8'h01 << i_bit_sel);
         OP_FILE_TO_FILE: res = opnd_f;
         OP_WORKING_TO_FILE: res = i_operand_w;
         default: res = RESULT_RST;
      endcase
      if (arith) begin
         res = sum[7:0];
      end
      mask = flag_mask(i_exec_op);
      new_flags[NEGATIVE_BIT] = res[7];
      new_flags[SIGNED_OVERFLOW_BIT] = arith & sum[8];
      new_flags[ZERO_BIT] = (res == 8'h00);
      new_flags[NIBBLE_CARRY_BIT] = arith & sum[9];
      new_flags[CARRY_BIT] = arith & sum[10];
   end

   // next state: the executing instruction owns the flags over a port write
   always_comb begin
      s_d = s_q;
      s_d.result_we = 1'b0;
      s_d.rdata = 8'h00;
      if (i_reg_rd && (i_reg_addr == ALU_FLAGS_OFS)) begin
         s_d.rdata = flags_byte;
      end
      if (i_reg_wr && (i_reg_addr == ALU_FLAGS_OFS)) begin
         s_d.flags = i_reg_wdata[FLAG_W-1:0];
      end
      // a port write beside an executing instruction is lost; software must not mix them
      if (i_exec_valid) begin
         s_d.result = res;
         if (i_dest_is_flags && (mask != MASK_NONE)) begin
            // result dropped, flags updated by the operation instead
            s_d.flags = (s_q.flags & ~mask) | (new_flags & mask);
         end else if (i_dest_is_flags) begin
            s_d.flags = res[FLAG_W-1:0];
         end else begin
            s_d.result_we = 1'b1;
            s_d.flags = (s_q.flags & ~mask) | (new_flags & mask);
         end
      end
   end

   // flags power up cleared so simulation never sees an unknown flag
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s_q <= '{flags: ALU_FLAGS_RST, result: RESULT_RST, result_we: 1'b0, rdata: 8'h00};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_reg_rdata = s_q.rdata;
   assign o_result = s_q.result;
   assign o_result_we = s_q.result_we;
   assign o_flags = s_q.flags;

   // checks on the flag register behaviour
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   // instructions whose result goes to a file other than the flags
   logic plain_exec;
   assign plain_exec = i_exec_valid && !i_dest_is_flags;

   flags_as_source_a: assert property (
      (i_exec_valid && i_src_is_flags && (i_exec_op == OP_FILE_TO_FILE))
      |=> (o_result == {3'h0, $past(o_flags)}))
      else $error("flag register not read as source operand");

   result_dropped_a: assert property (
      (i_exec_valid && i_dest_is_flags && (flag_mask(i_exec_op) != MASK_NONE))
      |=> !o_result_we)
      else $error("result written although flags were destination");

   clear_sets_zero_a: assert property (
      (i_exec_valid && i_dest_is_flags && (i_exec_op == OP_CLEAR_FILE))
      |=> (o_flags == ($past(o_flags) | MASK_ZERO)))
      else $error("clear of flag register did not set only zero");

   moves_keep_flags_a: assert property (
      (plain_exec && (i_exec_op inside {OP_NIBBLE_SWAP, OP_BIT_CLEAR, OP_BIT_SET,
         OP_FILE_TO_FILE, OP_WORKING_TO_FILE}))
      |=> $stable(o_flags))
      else $error("flags changed by a non flag instruction");

   sub_borrow_a: assert property (
      (plain_exec && (i_exec_op == OP_SUB) && !i_src_is_flags)
      |=> (o_flags[CARRY_BIT] == ($past(i_operand_f) >= $past(i_operand_w))))
      else $error("carry is not the inverted borrow in subtraction");

   upper_bits_zero_a: assert property (
      (i_reg_rd && (i_reg_addr == ALU_FLAGS_OFS))
      |=> (o_reg_rdata == {3'h0, $past(o_flags)}))
      else $error("flag register read back wrong or upper bits set");

   negative_flag_a: assert property (
      (plain_exec && flag_mask(i_exec_op)[NEGATIVE_BIT])
      |=> (o_flags[NEGATIVE_BIT] == o_result[7]))
      else $error("negative flag differs from result msb");

   overflow_flag_a: assert property (
      (plain_exec && (i_exec_op == OP_ADD) && !i_src_is_flags)
      |=> (o_flags[SIGNED_OVERFLOW_BIT] ==
           (($past(i_operand_f[7]) == $past(i_operand_w[7]))
            && (o_result[7] != $past(i_operand_f[7])))))
      else $error("overflow flag wrong for signed add");

   zero_flag_a: assert property (
      (plain_exec && flag_mask(i_exec_op)[ZERO_BIT])
      |=> (o_flags[ZERO_BIT] == (o_result == 8'h00)))
      else $error("zero flag does not match result");

   port_write_a: assert property (
      (i_reg_wr && (i_reg_addr == ALU_FLAGS_OFS) && !i_exec_valid)
      |=> (o_flags == $past(i_reg_wdata[FLAG_W-1:0])))
      else $error("port write not stored in flag register");

   rdata_idle_a: assert property (
      !(i_reg_rd && (i_reg_addr == ALU_FLAGS_OFS)) |=> (o_reg_rdata == 8'h00))
      else $error("read data present without a read of the flags");

   // instruction result, write enable and further flag checks
   nonflag_dest_store_a: assert property (
      (i_exec_valid && i_dest_is_flags && (i_exec_op == OP_WORKING_TO_FILE))
      |=> (o_flags == $past(i_operand_w[FLAG_W-1:0])))
      else $error("non flag move into flag register not stored");

   logic_keeps_carry_a: assert property (
      (plain_exec && (i_exec_op inside {OP_AND, OP_OR, OP_XOR}))
      |=> $stable(o_flags & ~MASK_LOGIC))
      else $error("logic operation changed overflow or carry flags");

   result_we_pulse_a: assert property (
      plain_exec |=> o_result_we)
      else $error("result not written for a plain destination");

   no_exec_write_a: assert property (
      !i_exec_valid |=> !o_result_we)
      else $error("result write without an instruction");

   sub_digit_borrow_a: assert property (
      (plain_exec && (i_exec_op == OP_SUB) && !i_src_is_flags)
      |=> (o_flags[NIBBLE_CARRY_BIT] == ($past(i_operand_f[3:0]) >= $past(i_operand_w[3:0]))))
      else $error("nibble carry is not the inverted digit borrow");

   sub_overflow_a: assert property (
      (plain_exec && (i_exec_op == OP_SUB) && !i_src_is_flags)
      |=> (o_flags[SIGNED_OVERFLOW_BIT] ==
           (($past(i_operand_f[7]) != $past(i_operand_w[7]))
            && (o_result[7] != $past(i_operand_f[7])))))
      else $error("overflow flag wrong for signed subtract");

   move_result_a: assert property (
      (i_exec_valid && (i_exec_op == OP_WORKING_TO_FILE))
      |=> (o_result == $past(i_operand_w)))
      else $error("working register move result wrong");

   clear_result_a: assert property (
      (plain_exec && (i_exec_op == OP_CLEAR_FILE))
      |=> ((o_result == 8'h00) && o_flags[ZERO_BIT]))
      else $error("clear of a file did not give zero with zero flag");

   // main scenarios worth seeing in coverage

   cover_add_carry: cover property (plain_exec && (i_exec_op == OP_ADD)
      ##1 o_flags[CARRY_BIT]);
   cover_clear_flags: cover property (i_exec_valid && i_dest_is_flags
      && (i_exec_op == OP_CLEAR_FILE));
   cover_read_back: cover property ((i_reg_wr && (i_reg_addr == ALU_FLAGS_OFS))
      ##1 (i_reg_rd && (i_reg_addr == ALU_FLAGS_OFS)));
   cover_sub_borrow: cover property (plain_exec && (i_exec_op == OP_SUB)
      ##1 !o_flags[CARRY_BIT]);
   cover_flags_both: cover property (i_exec_valid && i_src_is_flags
      && i_dest_is_flags);

endmodule : alu_status_flag_register

/* verification/tb_alu_status_flag_register.sv */
// self-checking bench for the alu status flag register
`timescale 1ns/10ps

module tb_alu_status_flag_register
   import alu_flags_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ev = 1'b0;
   alu_op_t op = OP_ADD;
   logic [7:0] w = 8'h00;
   logic [7:0] f = 8'h00;
   logic sf = 1'b0;
   logic df = 1'b0;
   logic [2:0] sel = 3'h0;
   logic [3:0] adr = 4'h0;
   logic [7:0] wd = 8'h00;
   logic rw = 1'b0;
   logic rr = 1'b0;
   logic [7:0] rdata, res;
   logic we;
   logic [4:0] flg;
   logic [4:0] exp_flags = 5'h00;
   int fails = 0;
   int checked = 0;
   int seed_val;

   alu_status_flag_register dut (.i_core_clk(clk), .i_nrst(nrst), .i_exec_valid(ev),
      .i_exec_op(op), .i_operand_w(w), .i_operand_f(f), .i_src_is_flags(sf),
      .i_dest_is_flags(df), .i_bit_sel(sel), .i_reg_addr(adr), .i_reg_wdata(wd),
      .i_reg_wr(rw), .i_reg_rd(rr), .o_reg_rdata(rdata), .o_result(res),
      .o_result_we(we), .o_flags(flg));

   // 50 MHz core clock
   always #10 clk = ~clk;

   // reference: {result, merged flags, flag-affecting}; subtraction adds the inverse
   function automatic logic [13:0] model(input alu_op_t o, input logic [7:0] wv, fv,
                                         input logic [4:0] fl, input logic [2:0] s);
      logic [8:0] sum;
      logic [4:0] h, m, g;
      logic [7:0] a, b, r;
      logic ci;
      a = fv;
      b = wv;
      ci = 1'b0;
      m = 5'h1F;
      case (o)
         OP_ADDC: ci = fl[0];
         OP_SUB: begin
            b = ~wv;
            ci = 1'b1;
         end
         OP_SUBB: begin
            b = ~wv;
            ci = fl[0];
         end
         OP_INC: begin
            b = 8'h00;
            ci = 1'b1;
         end
         OP_DEC: begin
            b = 8'hFE;
            ci = 1'b1;
         end
         OP_NEG: begin
            a = 8'h00;
            b = ~fv;
            ci = 1'b1;
         end
         OP_AND, OP_OR, OP_XOR: m = 5'h14;
         OP_CLEAR_FILE: m = 5'h04;
         OP_ADD: m = 5'h1F;
         default: m = 5'h00;
      endcase
      sum = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      case (o)
         OP_AND: r = fv & wv;
         OP_OR: r = fv | wv;
         OP_XOR: r = fv ^ wv;
         OP_CLEAR_FILE: r = 8'h00;
         OP_NIBBLE_SWAP: r = {fv[3:0], fv[7:4]};
         OP_BIT_CLEAR: r = fv & ~(8'h01 << s);
         OP_BIT_SET: r = fv | (8'h01 << s);
         OP_FILE_TO_FILE: r = fv;
         OP_WORKING_TO_FILE: r = wv;
         default: r = sum[7:0];
      endcase
      g = {r[7], (a[7] == b[7]) && (r[7] != a[7]), r == 8'h00, h[4], sum[8]};
      return {r, (g & m) | (fl & ~m), |m};
   endfunction : model

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one instruction and/or register write, checked one edge later
   task automatic step(input logic e, input alu_op_t o, input logic [7:0] wv, fv,
                       input logic s, d, input logic [2:0] b, input logic wr,
                       input logic [3:0] a, input logic [7:0] dat);
      logic [13:0] mo;
      @(posedge clk);
      ev <= e;
      op <= o;
      w <= wv;
      f <= fv;
      sf <= s;
      df <= d;
      sel <= b;
      rw <= wr;
      adr <= a;
      wd <= dat;
      mo = model(o, wv, s ? {3'h0, exp_flags} : fv, exp_flags, b);
      @(posedge clk);
      ev <= 1'b0;
      rw <= 1'b0;
      #1;
      if (e) begin
         exp_flags = (d && !mo[0]) ? mo[10:6] : mo[5:1];
         chk(res, mo[13:6]);
         chk({7'h00, we}, {7'h00, !d});
      end else if (wr && a == ALU_FLAGS_OFS) begin
         exp_flags = dat[4:0];
      end
      chk({3'h0, flg}, {3'h0, exp_flags});
   endtask : step

   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      rr <= 1'b1;
      adr <= a;
      @(posedge clk);
      rr <= 1'b0;
      #1 chk(rdata, (a == ALU_FLAGS_OFS) ? {3'h0, exp_flags} : 8'h00);
      @(posedge clk);
      #1 chk(rdata, 8'h00);
   endtask : rd

   task automatic complete_run();
      $display("checks %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   // watchdog sized well above the under nine hundred cycles of the sequence
   initial begin
      #(20 * 20000);
      fails++;
      complete_run();
   end

   initial begin
      seed_val = $urandom(79);
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      #1 chk({3'h0, flg}, 8'h00);
      // register port: upper bits dropped, unmapped place ignored
      step(0, OP_ADD, 0, 0, 0, 0, 0, 1, ALU_FLAGS_OFS, 8'hFF);
      rd(ALU_FLAGS_OFS);
      step(0, OP_ADD, 0, 0, 0, 0, 0, 1, 4'h5, 8'h00);
      rd(4'h5);
      // clear-file on the flags touches zero only
      step(0, OP_ADD, 0, 0, 0, 0, 0, 1, ALU_FLAGS_OFS, 8'h1B);
      step(1, OP_CLEAR_FILE, 8'h55, 8'h33, 0, 1, 0, 0, 0, 0);
      rd(ALU_FLAGS_OFS);
      // sign change corners, borrow corner, write lost to a concurrent instruction
      step(1, OP_ADD, 8'h01, 8'h7F, 0, 0, 0, 0, 0, 0);
      step(1, OP_SUB, 8'h01, 8'h00, 0, 0, 0, 0, 0, 0);
      step(1, OP_SUB, 8'h01, 8'h80, 0, 0, 0, 1, ALU_FLAGS_OFS, 8'h00);
      step(1, OP_FILE_TO_FILE, 0, 8'hAA, 1, 0, 0, 0, 0, 0);
      step(1, OP_BIT_SET, 0, 0, 1, 1, 3'h5, 0, 0, 0);
      // every op code, random operands, flags as source and destination now and then
      for (int i = 0; i < 400; i++) begin
         step(1, alu_op_t'(i % 16), 8'($urandom), 8'($urandom), ($urandom % 4) == 0,
              ($urandom % 4) == 0, 3'($urandom), 0, 0, 0);
         if (i % 50 == 0) rd(ALU_FLAGS_OFS);
      end
      complete_run();
   end
endmodule : tb_alu_status_flag_register
